// [common/mrs_pkg.sv]
/*
  Shared constants for the management-mode state save engine: region
  layout, save map offsets, slot tables and reset values.
  Assumes a 32-bit physical address space and 32-bit memory words.
*/
package mrs_pkg;

  // ----------------------------------------------------------------
  // Region layout
  // ----------------------------------------------------------------
  localparam logic [31:0] MRS_BASE_RESET     = 32'h0003_0000;
  localparam logic [31:0] MRS_REGION_SIZE    = 32'h0001_0000;
  localparam logic [31:0] MRS_HANDLER_OFFSET = 32'h0000_8000;
  localparam logic [31:0] MRS_SAVE_LOW       = 32'h0000_FE00;
  localparam logic [31:0] MRS_SAVE_HIGH      = 32'h0000_FFFF;
  localparam logic [15:0] MRS_SAVE_REL_TOP   = 16'h7FFF;
  localparam logic [15:0] MRS_SAVE_REL_BOT   = 16'h7E00;

  // ----------------------------------------------------------------
  // Save map offsets, relative to base plus handler offset
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_SAVED_CONTROL_REG_ZERO    = 16'h7FFC;
  localparam logic [15:0] OFS_SAVED_PAGE_DIR_BASE       = 16'h7FF8;
  localparam logic [15:0] OFS_SAVED_FLAGS_WORD          = 16'h7FF4;
  localparam logic [15:0] OFS_SAVED_INSTRUCTION_POINTER = 16'h7FF0;
  localparam logic [15:0] OFS_SAVED_DEST_INDEX          = 16'h7FEC;
  localparam logic [15:0] OFS_SAVED_SRC_INDEX           = 16'h7FE8;
  localparam logic [15:0] OFS_SAVED_BASE_POINTER        = 16'h7FE4;
  localparam logic [15:0] OFS_SAVED_STACK_POINTER       = 16'h7FE0;
  localparam logic [15:0] OFS_SAVED_GPR_B               = 16'h7FDC;
  localparam logic [15:0] OFS_SAVED_GPR_D               = 16'h7FD8;
  localparam logic [15:0] OFS_SAVED_GPR_C               = 16'h7FD4;
  localparam logic [15:0] OFS_SAVED_GPR_A               = 16'h7FD0;
  localparam logic [15:0] OFS_SAVED_DEBUG_STATUS        = 16'h7FCC;
  localparam logic [15:0] OFS_SAVED_DEBUG_CONTROL       = 16'h7FC8;
  localparam logic [15:0] OFS_SAVED_TASK_SELECTOR       = 16'h7FC4;
  localparam logic [15:0] OFS_RESERVED_SLOT             = 16'h7FC0;
  localparam logic [15:0] OFS_SAVED_SEG_G               = 16'h7FBC;
  localparam logic [15:0] OFS_SAVED_SEG_F               = 16'h7FB8;
  localparam logic [15:0] OFS_SAVED_DATA_SEG            = 16'h7FB4;
  localparam logic [15:0] OFS_SAVED_STACK_SEG           = 16'h7FB0;
  localparam logic [15:0] OFS_SAVED_CODE_SEG            = 16'h7FAC;
  localparam logic [15:0] OFS_SAVED_EXTRA_SEG           = 16'h7FA8;
  localparam logic [15:0] OFS_HALT_RESTART_WORD         = 16'h7F02;
  localparam logic [15:0] OFS_IO_RESTART_WORD           = 16'h7F00;
  localparam logic [15:0] OFS_SAVE_FORMAT_REVISION      = 16'h7EFC;
  localparam logic [15:0] OFS_SAVED_BASE_RELOCATION     = 16'h7EF8;

  // ----------------------------------------------------------------
  // Slot tables
  // ----------------------------------------------------------------
  localparam int          MRS_CTX_WORDS     = 21;
  localparam logic [4:0]  MRS_SLOT_LAST     = 5'd23;
  localparam logic [4:0]  MRS_SLOT_RESTART  = 5'd21;
  localparam logic [4:0]  MRS_SLOT_REVISION = 5'd22;
  localparam logic [4:0]  MRS_SLOT_BASE     = 5'd23;
  localparam logic [4:0]  MRS_SLOT_SEL_LOW  = 5'd14;
  localparam logic [4:0]  MRS_SLOT_SEL_HIGH = 5'd20;
  localparam logic [3:0]  MRS_RESTORE_LAST  = 4'd11;
  localparam logic [31:0] MRS_SEL_MASK      = 32'h0000_FFFF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] MRS_WORD_RESET    = 32'h0000_0000;
  localparam logic [15:0] MRS_HALF_RESET    = 16'h0000;
  localparam logic [31:0] MRS_CR4_IN_MODE   = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SAVE    = 3'b001,
    ST_HANDLER = 3'b010,
    ST_RESTORE = 3'b011,
    ST_EXIT    = 3'b100
  } mrs_state_type;

endpackage : mrs_pkg

// [design/mrs_mgmt_ram_save.sv]
/*
  Management-mode entry and resume engine: catches the management
  interrupt, writes the context image into management RAM, signals the
  mode on an active-low pin, points the fetch unit at the handler and
  reloads the writable images on resume.
  Assumes a single-word memory port on the same clock that answers each
  request with one ack cycle, and a core that freezes while busy is high.
*/
`timescale 1ns/1ps
module mrs_mgmt_ram_save
  import mrs_pkg::*;
#(
  parameter logic [31:0] REVISION_ID = 32'h0000_0001,  // Arbitrary value
  parameter int          HIDDEN_W    = 384
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset,
  // Management interrupt pin, active low, asynchronous
  input  wire logic                          sysMgmtInterruptN,
  // Core side, same clock
  input  wire logic                          resumeFromMgmt,
  input  wire logic [MRS_CTX_WORDS*32-1:0]   ctxSnapshot,
  input  wire logic [15:0]                   haltRestartIn,
  input  wire logic [15:0]                   ioRestartIn,
  input  wire logic [31:0]                   controlRegFourIn,
  input  wire logic [HIDDEN_W-1:0]           hiddenDescIn,
  output logic                               busy,
  output logic                               handlerFetch,
  output logic [31:0]                        handlerFetchAddr,
  output logic                               resumeDone,
  output logic [MRS_CTX_WORDS*32-1:0]        ctxRestore,
  output logic [15:0]                        haltRestartOut,
  output logic [15:0]                        ioRestartOut,
  output logic [31:0]                        controlRegFourOut,
  output logic [HIDDEN_W-1:0]                hiddenDescOut,
  // Region description for the system logic
  output logic                               mgmtActivePinN,
  output logic [31:0]                        mgmtRegionBase,
  output logic [31:0]                        mgmtRegionTop,
  // Management RAM port, same clock
  output logic                               memReq,
  output logic                               memWrite,
  output logic [31:0]                        memAddr,
  output logic [31:0]                        memWdata,
  input  wire logic [31:0]                   memRdata,
  input  wire logic                          memAck
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] slotOffset(input logic [4:0] idx);
    case (idx)
      5'd0:    slotOffset = OFS_SAVED_CONTROL_REG_ZERO;
      5'd1:    slotOffset = OFS_SAVED_PAGE_DIR_BASE;
      5'd2:    slotOffset = OFS_SAVED_FLAGS_WORD;
      5'd3:    slotOffset = OFS_SAVED_INSTRUCTION_POINTER;
      5'd4:    slotOffset = OFS_SAVED_DEST_INDEX;
      5'd5:    slotOffset = OFS_SAVED_SRC_INDEX;
      5'd6:    slotOffset = OFS_SAVED_BASE_POINTER;
      5'd7:    slotOffset = OFS_SAVED_STACK_POINTER;
      5'd8:    slotOffset = OFS_SAVED_GPR_B;
      5'd9:    slotOffset = OFS_SAVED_GPR_D;
      5'd10:   slotOffset = OFS_SAVED_GPR_C;
      5'd11:   slotOffset = OFS_SAVED_GPR_A;
      5'd12:   slotOffset = OFS_SAVED_DEBUG_STATUS;
      5'd13:   slotOffset = OFS_SAVED_DEBUG_CONTROL;
      5'd14:   slotOffset = OFS_SAVED_TASK_SELECTOR;
      5'd15:   slotOffset = OFS_SAVED_SEG_G;
      5'd16:   slotOffset = OFS_SAVED_SEG_F;
      5'd17:   slotOffset = OFS_SAVED_DATA_SEG;
      5'd18:   slotOffset = OFS_SAVED_STACK_SEG;
      5'd19:   slotOffset = OFS_SAVED_CODE_SEG;
      5'd20:   slotOffset = OFS_SAVED_EXTRA_SEG;
      5'd21:   slotOffset = OFS_IO_RESTART_WORD;
      5'd22:   slotOffset = OFS_SAVE_FORMAT_REVISION;
      default: slotOffset = OFS_SAVED_BASE_RELOCATION;
    endcase
  endfunction : slotOffset

  // Writable images only: flags, pointer, eight GPRs, restart pair, base
  function automatic logic [4:0] restoreSlot(input logic [3:0] k);
    case (k)
      4'd10:   restoreSlot = MRS_SLOT_RESTART;
      4'd11:   restoreSlot = MRS_SLOT_BASE;
      default: restoreSlot = 5'(k) + 5'd2;
    endcase
  endfunction : restoreSlot

  function automatic logic [31:0] slotAddr(input logic [31:0] base, input logic [4:0] idx);
    slotAddr = base + MRS_HANDLER_OFFSET + {16'h0000, slotOffset(idx)};
  endfunction : slotAddr

  // Entry is taken from idle only; a request seen during the mode waits
  // in the pending flag, since the mode does not nest
  function automatic logic entryHit(input mrs_state_type st, input logic edgeSeen,
                                    input logic pendSeen);
    entryHit = (st == ST_IDLE) && (edgeSeen || pendSeen);
  endfunction : entryHit

  // ----------------------------------------------------------------
  // Interrupt pin synchroniser and edge catch
  // ----------------------------------------------------------------
  logic          smiMeta_reg;
  logic          smiSync_reg;
  logic          smiPrev_reg;
  logic          smiEdge;
  logic          pendingSmi_reg;
  mrs_state_type state_reg;
  logic [4:0]    slot_reg;
  logic [3:0]    rcnt_reg;
  logic [31:0]   base_reg;
  logic [31:0]   newBase_reg;
  logic [31:0]   saveData;
  logic [31:0]   cr4Saved_reg;
  logic [HIDDEN_W-1:0] hiddenSaved_reg;
  logic          memDone;
  logic          entryNow;

  // The pin is inverted before the first stage, so reset loads the idle
  // level and no false edge follows reset
  always_ff @(posedge clk) begin
    if (reset) begin
      smiMeta_reg <= 1'b0;
      smiSync_reg <= 1'b0;
      smiPrev_reg <= 1'b0;
    end else begin
      smiMeta_reg <= ~sysMgmtInterruptN;
      smiSync_reg <= smiMeta_reg;
      smiPrev_reg <= smiSync_reg;
    end
  end

  assign smiEdge = smiSync_reg & ~smiPrev_reg;
  assign memDone = memReq & memAck;
  assign entryNow = entryHit(state_reg, smiEdge, pendingSmi_reg);

  // ----------------------------------------------------------------
  // One request held over while in the mode
  // Further requests in the same stay merge into it
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pendingSmi_reg <= 1'b0;
    end else if (smiEdge && state_reg != ST_IDLE) begin
      pendingSmi_reg <= 1'b1;
    end else if (state_reg == ST_IDLE) begin
      pendingSmi_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      slot_reg  <= 5'd0;
      rcnt_reg  <= 4'd0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          slot_reg <= 5'd0;
          rcnt_reg <= 4'd0;
          if (entryNow) begin
            state_reg <= ST_SAVE;
          end
        end
        ST_SAVE: begin
          if (memDone) begin
            if (slot_reg == MRS_SLOT_LAST) begin
              state_reg <= ST_HANDLER;
            end else begin
              slot_reg <= slot_reg + 5'd1;
            end
          end
        end
        ST_HANDLER: begin
          // A resume pulse outside this phase is ignored
          if (resumeFromMgmt) begin
            state_reg <= ST_RESTORE;
          end
        end
        ST_RESTORE: begin
          if (memDone) begin
            if (rcnt_reg == MRS_RESTORE_LAST) begin
              state_reg <= ST_EXIT;
            end else begin
              rcnt_reg <= rcnt_reg + 4'd1;
            end
          end
        end
        ST_EXIT: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Image data; selector images carry zero in their upper half
  // ----------------------------------------------------------------
  always_comb begin
    saveData = MRS_WORD_RESET;
    if (slot_reg == MRS_SLOT_RESTART) begin
      saveData = {haltRestartIn, ioRestartIn};
    end else if (slot_reg == MRS_SLOT_REVISION) begin
      saveData = REVISION_ID;
    end else if (slot_reg == MRS_SLOT_BASE) begin
      saveData = base_reg;
    end else begin
      saveData = ctxSnapshot[slot_reg*32 +: 32];
      if (slot_reg >= MRS_SLOT_SEL_LOW && slot_reg <= MRS_SLOT_SEL_HIGH) begin
        saveData = saveData & MRS_SEL_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory port; one idle cycle between words keeps the ack simple
  // at the price of one extra cycle per word
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      memReq   <= 1'b0;
      memWrite <= 1'b0;
      memAddr  <= MRS_WORD_RESET;
      memWdata <= MRS_WORD_RESET;
    end else if (memDone) begin
      memReq   <= 1'b0;
      memWrite <= 1'b0;
    end else if (!memReq && state_reg == ST_SAVE) begin
      memReq   <= 1'b1;
      memWrite <= 1'b1;
      memAddr  <= slotAddr(base_reg, slot_reg);
      memWdata <= saveData;
    end else if (!memReq && state_reg == ST_RESTORE) begin
      memReq   <= 1'b1;
      memWrite <= 1'b0;
      memAddr  <= slotAddr(base_reg, restoreSlot(rcnt_reg));
      memWdata <= MRS_WORD_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Region base and its relocation on resume
  // The field is read on every resume; an untouched one reloads the same base
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      base_reg    <= MRS_BASE_RESET;
      newBase_reg <= MRS_BASE_RESET;
    end else if (state_reg == ST_RESTORE && memDone && !memWrite
                 && restoreSlot(rcnt_reg) == MRS_SLOT_BASE) begin
      newBase_reg <= memRdata;
    end else if (state_reg == ST_EXIT) begin
      base_reg <= newBase_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mgmtRegionBase <= MRS_BASE_RESET;
      mgmtRegionTop  <= MRS_BASE_RESET + MRS_REGION_SIZE - 32'h0000_0001;
    end else begin
      mgmtRegionBase <= base_reg;
      mgmtRegionTop  <= base_reg + MRS_REGION_SIZE - 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Restored images; read-only ones return the value taken at entry
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      ctxRestore     <= '0;
      haltRestartOut <= MRS_HALF_RESET;
      ioRestartOut   <= MRS_HALF_RESET;
    end else if (entryNow) begin
      ctxRestore     <= ctxSnapshot;
      haltRestartOut <= haltRestartIn;
      ioRestartOut   <= ioRestartIn;
    end else if (state_reg == ST_RESTORE && memDone) begin
      // Only writable slots are read back; a changed read-only image is ignored
      if (restoreSlot(rcnt_reg) == MRS_SLOT_RESTART) begin
        haltRestartOut <= memRdata[31:16];
        ioRestartOut   <= memRdata[15:0];
      end else if (restoreSlot(rcnt_reg) != MRS_SLOT_BASE) begin
        ctxRestore[restoreSlot(rcnt_reg)*32 +: 32] <= memRdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Internal-only state: control register four and hidden descriptors
  // Breakpoint, FPU, range, fault-address and similar state has no path
  // here at all, so software must keep it itself
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      cr4Saved_reg      <= MRS_WORD_RESET;
      hiddenSaved_reg   <= '0;
      controlRegFourOut <= MRS_WORD_RESET;
      hiddenDescOut     <= '0;
    end else if (entryNow) begin
      // Control register four reads zero for the whole stay
      cr4Saved_reg      <= controlRegFourIn;
      hiddenSaved_reg   <= hiddenDescIn;
      controlRegFourOut <= MRS_CR4_IN_MODE;
    end else if (state_reg == ST_EXIT) begin
      controlRegFourOut <= cr4Saved_reg;
      hiddenDescOut     <= hiddenSaved_reg;
    end else if (state_reg == ST_IDLE) begin
      controlRegFourOut <= controlRegFourIn;
      hiddenDescOut     <= hiddenDescIn;
    end
  end

  // ----------------------------------------------------------------
  // Outward signalling and handler fetch
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      mgmtActivePinN   <= 1'b1;
      busy             <= 1'b0;
      handlerFetch     <= 1'b0;
      handlerFetchAddr <= MRS_BASE_RESET + MRS_HANDLER_OFFSET;
      resumeDone       <= 1'b0;
    end else begin
      handlerFetch <= 1'b0;
      resumeDone   <= 1'b0;
      // Pin falls and busy rises together, so the core freezes before the first save
      if (entryNow) begin
        mgmtActivePinN <= 1'b0;
        busy           <= 1'b1;
      end else if (state_reg == ST_SAVE && memDone && slot_reg == MRS_SLOT_LAST) begin
        busy             <= 1'b0;
        handlerFetch     <= 1'b1;
        handlerFetchAddr <= base_reg + MRS_HANDLER_OFFSET;
      end else if (state_reg == ST_HANDLER && resumeFromMgmt) begin
        busy <= 1'b1;
      end else if (state_reg == ST_EXIT) begin
        mgmtActivePinN <= 1'b1;
        busy           <= 1'b0;
        resumeDone     <= 1'b1;
      end
    end
  end

endmodule : mrs_mgmt_ram_save

// [verification/mrs_mem_model.sv]
/* Management RAM partner model: word memory with a per-request ack lag.
   Assumes the engine holds each request until it is acknowledged. */
`timescale 1ns/1ps
module mrs_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Request side
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  input  wire logic [1:0]  lag,
  // Answer side
  output logic             memAck,
  output logic [31:0]      memRdata
);
  logic [31:0] ram [logic [31:0]];
  logic [31:0] addrLog [$];
  int          waitCnt;
  initial memAck = 1'b0;
  initial memRdata = 32'h5A5A_5A5A;
  // -------------------------------------------------------------
  // Decode of the whole region, ack after lag cycles
  // -------------------------------------------------------------
  // Idle data flips every cycle so a stale read never matches
  always @(posedge clk) begin
    memAck   <= 1'b0;
    memRdata <= ~memRdata;
    if (reset) begin
      waitCnt <= 0;
    end else if (memReq && !memAck) begin
      if (waitCnt < lag) begin
        waitCnt <= waitCnt + 1;
      end else begin
        waitCnt <= 0;
        memAck  <= 1'b1;
        if (memWrite) begin
          ram[memAddr] = memWdata;
          addrLog.push_back(memAddr);
        end else begin
          memRdata <= ram.exists(memAddr) ? ram[memAddr] : 32'hC0DE_0BAD;
        end
      end
    end
  end
endmodule : mrs_mem_model

// [verification/mrs_mgmt_ram_save_chk.sv]
/* Port checker for the management-mode save engine.
   Assumes one clock domain and the synchronous high reset. */
`timescale 1ns/1ps
module mrs_mgmt_ram_save_chk
  import mrs_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Observed ports
  input wire logic        sysMgmtInterruptN,
  input wire logic        busy,
  input wire logic        handlerFetch,
  input wire logic [31:0] handlerFetchAddr,
  input wire logic        resumeDone,
  input wire logic [31:0] controlRegFourOut,
  input wire logic        mgmtActivePinN,
  input wire logic [31:0] mgmtRegionBase,
  input wire logic [31:0] mgmtRegionTop,
  input wire logic        memReq,
  input wire logic        memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic        memAck
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [31:0] saveOfs;
  assign saveOfs = memAddr - mgmtRegionBase - MRS_HANDLER_OFFSET;
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  property p_base_reset; $fell(reset) |-> mgmtRegionBase == MRS_BASE_RESET; endproperty
  a_base_reset: assert property (p_base_reset) else $error("base not at reset value");
  property p_top; !$changed(mgmtRegionBase) |-> mgmtRegionTop == mgmtRegionBase + MRS_SAVE_HIGH;
  endproperty
  a_top: assert property (p_top) else $error("region top wrong");
  property p_fetch; handlerFetch |-> handlerFetchAddr == mgmtRegionBase + MRS_HANDLER_OFFSET;
  endproperty
  a_fetch: assert property (p_fetch) else $error("handler fetch address wrong");
  property p_save_win; memReq && memWrite |-> saveOfs >= 32'h7E00 && saveOfs <= 32'h7FFF;
  endproperty
  a_save_win: assert property (p_save_win) else $error("write outside save area");
  property p_entry; $fell(sysMgmtInterruptN) && mgmtActivePinN && !busy |-> ##[1:6] !mgmtActivePinN;
  endproperty
  a_entry: assert property (p_entry) else $error("active pin not asserted");
  property p_ram_in_mode; memReq |-> !mgmtActivePinN; endproperty
  a_ram_in_mode: assert property (p_ram_in_mode) else $error("RAM access outside mode");
  property p_cr4; !mgmtActivePinN && $past(!mgmtActivePinN) |-> controlRegFourOut == MRS_CR4_IN_MODE;
  endproperty
  a_cr4: assert property (p_cr4) else $error("control reg four not clear in mode");
  property p_done; resumeDone |-> mgmtActivePinN && !busy && $past(!mgmtActivePinN); endproperty
  a_done: assert property (p_done) else $error("exit not signalled with resume");
  property p_sel;
    memReq && memWrite && saveOfs[15:0] inside {[16'h7FA8:16'h7FBC], 16'h7FC4}
      |-> memWdata[31:16] == 16'h0000;
  endproperty
  a_sel: assert property (p_sel) else $error("selector upper half not zero");
  c_fetch: cover property (handlerFetch);
  c_done: cover property (resumeDone);
  c_read: cover property (memReq && !memWrite && memAck);
endmodule : mrs_mgmt_ram_save_chk

bind mrs_mgmt_ram_save mrs_mgmt_ram_save_chk u_chk (
  .clk, .reset, .sysMgmtInterruptN, .busy, .handlerFetch, .handlerFetchAddr, .resumeDone,
  .controlRegFourOut, .mgmtActivePinN, .mgmtRegionBase, .mgmtRegionTop, .memReq, .memWrite,
  .memAddr, .memWdata, .memAck
);

// [verification/testbench.sv]
/* Self-checking bench: queue-based reference of the save image, random core
   state and memory lag. Assumes mrs_mem_model and the bound checker. */
`timescale 1ns/1ps
module testbench
  import mrs_pkg::*;
;
  localparam logic [31:0] REV = 32'h0000_00C3;  // Arbitrary value
  localparam int          HW  = 384;
  localparam int          CW  = MRS_CTX_WORDS * 32;
  logic                        clk, reset, sysMgmtInterruptN, resumeFromMgmt;
  logic [MRS_CTX_WORDS*32-1:0] ctxSnapshot, ctxRestore, savedSnap;
  logic [15:0]                 haltRestartIn, ioRestartIn, haltRestartOut, ioRestartOut;
  logic [31:0]                 controlRegFourIn, controlRegFourOut, handlerFetchAddr, memRdata;
  logic [31:0]                 mgmtRegionBase, mgmtRegionTop, memAddr, memWdata;
  logic [31:0]                 expBase, savedCr4, expRestart;
  logic [HW-1:0]               hiddenDescIn, hiddenDescOut, savedHid;
  logic                        busy, handlerFetch, resumeDone, mgmtActivePinN;
  logic                        memReq, memWrite, memAck;
  logic [1:0]                  lag;
  int                          mismatches, numChecks, seed = 73;

  mrs_mgmt_ram_save #(.REVISION_ID(REV), .HIDDEN_W(HW)) dut (
    .clk, .reset, .sysMgmtInterruptN, .resumeFromMgmt, .ctxSnapshot, .haltRestartIn,
    .ioRestartIn, .controlRegFourIn, .hiddenDescIn, .busy, .handlerFetch, .handlerFetchAddr,
    .resumeDone, .ctxRestore, .haltRestartOut, .ioRestartOut, .controlRegFourOut,
    .hiddenDescOut, .mgmtActivePinN, .mgmtRegionBase, .mgmtRegionTop, .memReq, .memWrite,
    .memAddr, .memWdata, .memRdata, .memAck);
  mrs_mem_model mem (.clk, .reset, .memReq, .memWrite, .memAddr, .memWdata, .lag, .memAck,
    .memRdata);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) lag <= 2'($random(seed));
  initial begin
    #(25 * 20000);
    mismatches++;
    $display("Error %0t: watchdog expired", $time);
    end_of_test();
  end

  task automatic check(input logic [CW-1:0] got, input logic [CW-1:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : check

  // Save image offset of write number i
  function automatic logic [15:0] ofs(input int i);
    if (i < 15) return 16'h7FFC - 16'(4 * i);
    if (i < 21) return 16'h7FF8 - 16'(4 * i);
    return (i == 21) ? 16'h7F00 : (i == 22) ? 16'h7EFC : 16'h7EF8;
  endfunction : ofs

  task automatic stir();
    logic [MRS_CTX_WORDS*32-1:0] s;
    logic [HW-1:0]               h;
    for (int i = 0; i < MRS_CTX_WORDS; i++) s[i*32 +: 32] = $random(seed);
    for (int i = 0; i < HW / 32; i++) h[i*32 +: 32] = $random(seed);
    @(posedge clk);
    ctxSnapshot                  <= s;
    hiddenDescIn                 <= h;
    {haltRestartIn, ioRestartIn} <= $random(seed);
    controlRegFourIn             <= $random(seed);
  endtask : stir

  task automatic enter();
    int          n;
    logic [31:0] a, e;
    stir();
    @(posedge clk) sysMgmtInterruptN <= 1'b0;
    #1;
    savedSnap = ctxSnapshot;
    savedCr4  = controlRegFourIn;
    savedHid  = hiddenDescIn;
    mem.addrLog.delete();
    n = 0;
    do @(posedge clk); while (handlerFetch !== 1'b1 && ++n < 500);
    sysMgmtInterruptN <= 1'b1;
    check(handlerFetchAddr, expBase + MRS_HANDLER_OFFSET, "fetch address");
    check(mem.addrLog.size(), 24, "save count");
    for (int i = 0; i < 24; i++) begin
      a = expBase + MRS_HANDLER_OFFSET + ofs(i);
      e = (i < 21) ? savedSnap[i*32 +: 32] : (i == 21) ? {haltRestartIn, ioRestartIn} :
          (i == 22) ? REV : expBase;
      if (i > 13 && i < 21) e[31:16] = 16'h0000;
      check(mem.addrLog[i], a, "save address");
      check(mem.ram[a], e, "save data");
    end
    #1;
    check(mgmtActivePinN, 1'b0, "active pin");
    check(controlRegFourOut, 32'h0, "cr4 in mode");
  endtask : enter

  // Handler edits writable images only, reserved ones left alone
  task automatic resume(input logic [31:0] newBase);
    int          n;
    logic [31:0] w, top;
    top = expBase + MRS_HANDLER_OFFSET;
    stir();
    for (int i = 2; i < 12; i++) begin
      w = $random(seed);
      mem.ram[top + ofs(i)] = w;
      savedSnap[i*32 +: 32] = w;
    end
    expRestart = $random(seed);
    mem.ram[top + ofs(21)] = expRestart;
    mem.ram[top + ofs(23)] = newBase;
    @(posedge clk) resumeFromMgmt <= 1'b1;
    @(posedge clk) resumeFromMgmt <= 1'b0;
    n = 0;
    do @(posedge clk); while (resumeDone !== 1'b1 && ++n < 500);
    check(mgmtActivePinN, 1'b1, "pin after exit");
    check(ctxRestore, savedSnap, "restored context");
    check({haltRestartOut, ioRestartOut}, expRestart, "restart words");
    check(controlRegFourOut, savedCr4, "cr4 restored");
    check(hiddenDescOut, savedHid, "hidden restored");
    check(mem.ram.exists(top + OFS_RESERVED_SLOT), 1'b0, "reserved slot");
    expBase = newBase;
    @(posedge clk);
    #1;
    check(mgmtRegionBase, expBase, "relocated base");
    check(mgmtRegionTop, expBase + 32'h0000_FFFF, "region top");
  endtask : resume

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    reset = 1'b1;
    sysMgmtInterruptN = 1'b1;
    resumeFromMgmt = 1'b0;
    ctxSnapshot = '0;
    hiddenDescIn = '0;
    {haltRestartIn, ioRestartIn, controlRegFourIn} = '0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check(mgmtRegionBase, 32'h0003_0000, "reset base");
    check(mgmtRegionTop, 32'h0003_FFFF, "reset top");
    check(handlerFetchAddr, 32'h0003_8000, "reset fetch");
    check(mgmtActivePinN, 1'b1, "reset pin");
    $display("Test reset done");
    expBase = MRS_BASE_RESET;
    for (int r = 0; r < 3; r++) begin
      enter();
      resume((r == 0) ? expBase : {8'h00, 8'($random(seed)), 16'h0000});
      $display("Test round %0d done", r);
    end
    end_of_test();
  end
endmodule : testbench
